// ### rtl/hmse_store_exec.sv
`timescale 1ns/1ps
`default_nettype none
module hmse_store_exec import hmse_pkg::*; (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESETN,
  // instruction issue
  input  wire logic        I_INSN_VALID,
  input  wire logic [31:0] I_INSN,
  output logic             O_INSN_READY,
  output logic             O_DONE,
  output logic             O_NOT_HANDLED,
  // register file read ports
  output logic      [4:0]  O_RD_BASE_IDX,
  input  wire logic [31:0] I_RD_BASE_DATA,
  output logic      [4:0]  O_RD_INDEX_IDX,
  input  wire logic [31:0] I_RD_INDEX_DATA,
  output logic      [4:0]  O_RD_SRC_IDX,
  input  wire logic [31:0] I_RD_SRC_DATA,
  // register file write port
  output logic             O_WB_VALID,
  output logic      [4:0]  O_WB_IDX,
  output logic      [31:0] O_WB_DATA,
  // machine state
  input  wire logic        I_DATA_RELOC,
  input  wire logic        I_USER_MODE,
  // translation answer for O_MEM_ADDR
  input  wire logic        I_TLB_HIT,
  input  wire logic        I_ZONE_NOACC,
  input  wire logic        I_ZONE_RDONLY,
  // memory store port
  output logic             O_MEM_VALID,
  input  wire logic        I_MEM_READY,
  output logic      [31:0] O_MEM_ADDR,
  output logic      [31:0] O_MEM_DATA,
  output logic      [2:0]  O_MEM_LEN,
  // exceptions
  output logic             O_DATA_STORAGE_EXC,
  output logic             O_DTLB_MISS_EXC
);

  hmse_state_t state_q;
  hmse_kind_t  kind_q;
  hmse_kind_t  dec_kind;
  logic [31:0] insn_q;
  logic [4:0]  src_idx_q;
  logic        first_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_data_q;
  logic [2:0]  mem_len_q;
  logic        done_q;
  logic        not_handled_q;
  logic        wb_valid_q;
  logic [4:0]  wb_idx_q;
  logic [31:0] wb_data_q;
  logic        dsi_q;
  logic        miss_q;
  logic [31:0] ea;
  logic        is_update;
  logic        is_indexed;
  logic        accept;
  logic        tlb_miss;
  logic        zone_fault;
  logic        fault;
  logic        mem_fire;
  logic        last_word;

  // decode: reserved bit 0 and a zero base on update forms are not
  // checked; such encodings simply execute with the fields as given
  always_comb begin
    dec_kind = K_NONE;
    case (I_INSN[OPC_MSB:OPC_LSB])
      OP_STH:   dec_kind = K_STH;
      OP_STHU:  dec_kind = K_STHU;
      OP_STMW:  dec_kind = K_STMW;
      OP_XFORM: begin
        case (I_INSN[XO_MSB:XO_LSB])
          XO_STHX:   dec_kind = K_STHX;
          XO_STHUX:  dec_kind = K_STHUX;
          XO_STHBRX: dec_kind = K_STHBRX;
          default:   dec_kind = K_NONE;
        endcase
      end
      default:  dec_kind = K_NONE;
    endcase
  end

  assign is_update  = (kind_q == K_STHU) || (kind_q == K_STHUX);
  assign is_indexed = (kind_q == K_STHX) || (kind_q == K_STHUX) ||
                      (kind_q == K_STHBRX);
  assign accept     = I_INSN_VALID && (state_q == ST_IDLE);

  hmse_ea u_ea (
    .i_base_field (insn_q[RA_MSB:RA_LSB]),
    .i_disp       (insn_q[D_MSB:D_LSB]),
    .i_update     (is_update),
    .i_indexed    (is_indexed),
    .i_base_data  (I_RD_BASE_DATA),
    .i_index_data (I_RD_INDEX_DATA),
    .o_ea         (ea)
  );

  // translation is checked for every word, a multiple store may cross pages
  assign tlb_miss   = I_DATA_RELOC && !I_TLB_HIT;
  assign zone_fault = I_DATA_RELOC && I_TLB_HIT &&
                      (I_ZONE_RDONLY ||
                       (I_ZONE_NOACC && I_USER_MODE));
  assign fault      = tlb_miss || zone_fault;
  assign mem_fire   = (state_q == ST_WRITE) && !fault && I_MEM_READY;
  assign last_word  = (kind_q != K_STMW) || (src_idx_q == GPR_LAST);

  assign O_INSN_READY = (state_q == ST_IDLE);
  assign O_MEM_VALID  = (state_q == ST_WRITE) && !fault;
  assign O_MEM_ADDR   = mem_addr_q;
  assign O_MEM_DATA   = mem_data_q;
  assign O_MEM_LEN    = mem_len_q;
  assign O_RD_BASE_IDX      = insn_q[RA_MSB:RA_LSB];
  assign O_RD_INDEX_IDX     = insn_q[RB_MSB:RB_LSB];
  assign O_RD_SRC_IDX       = src_idx_q;
  assign O_DONE             = done_q;
  assign O_NOT_HANDLED      = not_handled_q;
  assign O_WB_VALID         = wb_valid_q;
  assign O_WB_IDX           = wb_idx_q;
  assign O_WB_DATA          = wb_data_q;
  assign O_DATA_STORAGE_EXC = dsi_q;
  assign O_DTLB_MISS_EXC    = miss_q;

  // sequencing
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && dec_kind != K_NONE) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH:  state_q <= ST_WRITE;
        ST_WRITE: begin
          if (fault) begin
            state_q <= ST_IDLE;
          end else if (I_MEM_READY) begin
            state_q <= last_word ? ST_FINISH : ST_FETCH;
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // captured instruction and source register walk
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      insn_q    <= WORD_RST;
      kind_q    <= K_NONE;
      src_idx_q <= GPR_ZERO;
      first_q   <= 1'b0;
    end else if (accept) begin
      insn_q    <= I_INSN;
      kind_q    <= dec_kind;
      src_idx_q <= I_INSN[RS_MSB:RS_LSB];
      first_q   <= 1'b1;
    end else if (state_q == ST_FETCH) begin
      first_q   <= 1'b0;
    end else if (mem_fire && !last_word) begin
      src_idx_q <= src_idx_q + 5'h01;
    end
  end

  // store address, data and length
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mem_addr_q <= WORD_RST;
      mem_data_q <= WORD_RST;
      mem_len_q  <= LEN_HALF;
    end else if (state_q == ST_FETCH) begin
      if (first_q) begin
        mem_addr_q <= ea;
      end
      // byte at the address is the most significant valid byte
      case (kind_q)
        K_STHBRX: begin
          mem_data_q <= {16'h0000, I_RD_SRC_DATA[7:0],
                         I_RD_SRC_DATA[15:8]};
          mem_len_q  <= LEN_HALF;
        end
        K_STMW: begin
          mem_data_q <= I_RD_SRC_DATA;
          mem_len_q  <= LEN_WORD;
        end
        default: begin
          mem_data_q <= {16'h0000, I_RD_SRC_DATA[15:0]};
          mem_len_q  <= LEN_HALF;
        end
      endcase
    end else if (mem_fire && !last_word) begin
      mem_addr_q <= mem_addr_q + WORD_STEP;
    end
  end

  // completion and base writeback pulses
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      done_q        <= 1'b0;
      not_handled_q <= 1'b0;
      wb_valid_q    <= 1'b0;
      wb_idx_q      <= GPR_ZERO;
      wb_data_q     <= WORD_RST;
    end else begin
      done_q        <= mem_fire && last_word;
      not_handled_q <= accept && (dec_kind == K_NONE);
      // writeback only after the store went out, so a fault leaves base
      wb_valid_q    <= mem_fire && is_update;
      if (mem_fire && is_update) begin
        wb_idx_q  <= insn_q[RA_MSB:RA_LSB];
        wb_data_q <= mem_addr_q;
      end
    end
  end

  // exception pulses, a miss hides any zone result
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dsi_q  <= 1'b0;
      miss_q <= 1'b0;
    end else begin
      dsi_q  <= (state_q == ST_WRITE) && zone_fault;
      miss_q <= (state_q == ST_WRITE) && tlb_miss;
    end
  end

  // checks
  logic        fetch_first;
  logic [31:0] disp_sext;
  logic [31:0] offset_h;
  logic [15:0] src_half;
  logic [7:0]  src_lo;
  logic [7:0]  src_hi;
  logic        base_zero;

  assign fetch_first = (state_q == ST_FETCH) && first_q;
  assign disp_sext   = {{16{insn_q[D_MSB]}}, insn_q[D_MSB:D_LSB]};
  assign offset_h    = is_indexed ? I_RD_INDEX_DATA : disp_sext;
  assign src_half    = I_RD_SRC_DATA[15:0];
  assign src_lo      = I_RD_SRC_DATA[7:0];
  assign src_hi      = I_RD_SRC_DATA[15:8];
  assign base_zero   = (insn_q[RA_MSB:RA_LSB] == GPR_ZERO);

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence s_write_acc;
    mem_fire && is_update;
  endsequence

  sequence s_word_step;
    mem_fire && (kind_q == K_STMW) && !last_word;
  endsequence

  property p_disp_ea;
    fetch_first && !is_indexed && !base_zero
      |=> mem_addr_q == $past(I_RD_BASE_DATA) + $past(disp_sext);
  endproperty
  a_disp_ea: assert property (p_disp_ea)
    else $error("displacement address wrong");

  property p_zero_base;
    fetch_first && !is_update && base_zero
      |=> mem_addr_q == $past(offset_h);
  endproperty
  a_zero_base: assert property (p_zero_base)
    else $error("zero base not used");

  property p_update_base;
    fetch_first && is_update
      |=> mem_addr_q == $past(I_RD_BASE_DATA) + $past(offset_h);
  endproperty
  a_update_base: assert property (p_update_base)
    else $error("update form ignored base register");

  property p_half_data;
    (state_q == ST_FETCH) && (kind_q == K_STH || kind_q == K_STHX)
      |=> mem_data_q == {16'h0000, $past(src_half)}
          && mem_len_q == LEN_HALF;
  endproperty
  a_half_data: assert property (p_half_data)
    else $error("halfword data wrong");

  property p_indexed;
    fetch_first && is_indexed && !base_zero
      |=> mem_addr_q == $past(I_RD_BASE_DATA) + $past(I_RD_INDEX_DATA);
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address wrong");

  property p_reversed;
    (state_q == ST_FETCH) && (kind_q == K_STHBRX)
      |=> O_MEM_DATA[15:0] == {$past(src_lo), $past(src_hi)};
  endproperty
  a_reversed: assert property (p_reversed)
    else $error("byte reversal wrong");

  property p_sthu_wb;
    s_write_acc and (kind_q == K_STHU)
      |=> O_WB_VALID && O_WB_DATA == $past(O_MEM_ADDR)
          && O_WB_IDX == $past(O_RD_BASE_IDX);
  endproperty
  a_sthu_wb: assert property (p_sthu_wb)
    else $error("update writeback missing");

  property p_sthux_wb;
    s_write_acc and (kind_q == K_STHUX)
      |=> O_WB_VALID ##1 !O_WB_VALID && state_q == ST_IDLE;
  endproperty
  a_sthux_wb: assert property (p_sthux_wb)
    else $error("indexed update writeback wrong");

  property p_no_wb;
    O_WB_VALID |-> (kind_q == K_STHU) || (kind_q == K_STHUX);
  endproperty
  a_no_wb: assert property (p_no_wb)
    else $error("register written by non-update form");

  property p_word_step;
    s_word_step |=> state_q == ST_FETCH
      ##1 state_q == ST_WRITE
          && O_MEM_ADDR == $past(O_MEM_ADDR, 2) + WORD_STEP;
  endproperty
  a_word_step: assert property (p_word_step)
    else $error("multiple store address step wrong");

  property p_zone;
    (state_q == ST_WRITE) && I_DATA_RELOC && I_TLB_HIT && I_ZONE_RDONLY
      |-> !O_MEM_VALID ##1 O_DATA_STORAGE_EXC;
  endproperty
  a_zone: assert property (p_zone)
    else $error("read-only zone store not suppressed");

  property p_priv;
    (state_q == ST_WRITE) && I_DATA_RELOC && I_TLB_HIT
      && !I_ZONE_RDONLY && !I_USER_MODE |-> O_MEM_VALID;
  endproperty
  a_priv: assert property (p_priv)
    else $error("privileged store blocked");

  property p_miss;
    (state_q == ST_WRITE) && I_DATA_RELOC && !I_TLB_HIT
      |-> !O_MEM_VALID ##1 O_DTLB_MISS_EXC && !O_DATA_STORAGE_EXC;
  endproperty
  a_miss: assert property (p_miss)
    else $error("translation miss not raised");

  property p_exc_quiet;
    O_DATA_STORAGE_EXC || O_DTLB_MISS_EXC
      |-> !O_WB_VALID && !O_DONE && !O_MEM_VALID [*2];
  endproperty
  a_exc_quiet: assert property (p_exc_quiet)
    else $error("activity after exception");

endmodule
`default_nettype wire

// ### rtl/hmse_pkg.sv
// Function
// - displacement forms sign-extend the 16-bit field and add it to base
// - non-update forms with base field zero use the value zero as base
// - nonzero base field or update form reads the named base register
// - opcode 44 stores source bits 16:31 as a halfword, no register changes
// - indexed forms add the index register to the base, no displacement
// - opcode 31/918 stores bits 24:31 at the address, 16:23 at the next byte
// - opcode 45 stores the low halfword, then writes the address to base
// - opcode 31/439 stores at base plus index and writes address to base
// - opcode 31/407 stores at base-or-zero plus index, no register changes
// - update forms with base field zero run undefined, no program exception
// - indexed forms with reserved bits set run undefined, no exception
// - opcode 47 stores source through register 31 to words, step four
// - with relocation on, a zone violation suppresses the store, faults
// - no-access zones block user-mode stores only, never privileged ones
// - read-only zones block stores in both user and privileged modes
// - with relocation on, a translation miss faults instead of storing
package hmse_pkg;

  // instruction fields, bit 0 of the architecture is bit 31 here
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int RS_MSB  = 25;
  localparam int RS_LSB  = 21;
  localparam int RA_MSB  = 20;
  localparam int RA_LSB  = 16;
  localparam int RB_MSB  = 15;
  localparam int RB_LSB  = 11;
  localparam int XO_MSB  = 10;
  localparam int XO_LSB  = 1;
  localparam int D_MSB   = 15;
  localparam int D_LSB   = 0;

  // primary opcodes
  localparam logic [5:0] OP_STH   = 6'h2c;
  localparam logic [5:0] OP_STHU  = 6'h2d;
  localparam logic [5:0] OP_STMW  = 6'h2f;
  localparam logic [5:0] OP_XFORM = 6'h1f;

  // extended opcodes of the indexed group
  localparam logic [9:0] XO_STHX   = 10'h197;
  localparam logic [9:0] XO_STHUX  = 10'h1b7;
  localparam logic [9:0] XO_STHBRX = 10'h396;

  localparam logic [4:0]  GPR_ZERO  = 5'h00;
  localparam logic [4:0]  GPR_LAST  = 5'h1f;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [2:0]  LEN_HALF  = 3'h2;
  localparam logic [2:0]  LEN_WORD  = 3'h4;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH  = 2'b01,
    ST_WRITE  = 2'b11,
    ST_FINISH = 2'b10
  } hmse_state_t;

  typedef enum logic [2:0] {
    K_NONE   = 3'h0,
    K_STH    = 3'h1,
    K_STHU   = 3'h2,
    K_STHX   = 3'h3,
    K_STHUX  = 3'h4,
    K_STHBRX = 3'h5,
    K_STMW   = 3'h6
  } hmse_kind_t;

endpackage

// ### rtl/hmse_ea.sv
`timescale 1ns/1ps
`default_nettype none
module hmse_ea import hmse_pkg::*; (
  // instruction fields
  input  wire logic [4:0]  i_base_field,
  input  wire logic [15:0] i_disp,
  input  wire logic        i_update,
  input  wire logic        i_indexed,
  // register values
  input  wire logic [31:0] i_base_data,
  input  wire logic [31:0] i_index_data,
  // result
  output logic      [31:0] o_ea
);

  logic [31:0] base;
  logic [31:0] offset;

  // update forms always read the register, even a zero field
  assign base   = (!i_update && i_base_field == GPR_ZERO) ?
                  WORD_RST : i_base_data;
  assign offset = i_indexed ? i_index_data :
                  {{16{i_disp[15]}}, i_disp};
  assign o_ea   = base + offset;

endmodule
`default_nettype wire

// ### sim/hmse_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmse_mem_model (
  // clock
  input  wire logic        i_clk,
  // store port
  input  wire logic        i_valid,
  input  wire logic [31:0] i_addr,
  output logic             o_ready,
  // translation answer
  output logic             o_tlb_hit,
  output logic             o_zone_noacc,
  output logic             o_zone_rdonly,
  // test control
  input  wire logic        i_slow,
  input  wire logic [19:0] i_fault_page,
  input  wire logic [1:0]  i_fault_kind
);
  integer seed = 83497;
  logic   on_page;

  // answer follows the registered address alone; gating it with the
  // request would loop back through the request's own fault term
  assign on_page       = (i_addr[31:12] == i_fault_page);
  assign o_tlb_hit     = !(on_page && (i_fault_kind == 2'h1));
  assign o_zone_noacc  = on_page && (i_fault_kind == 2'h2);
  assign o_zone_rdonly = on_page && (i_fault_kind == 2'h3);

  // a slow port stalls three cycles in four on average
  initial o_ready = 1'b1;
  always @(negedge i_clk) begin
    if (!i_slow)
      o_ready <= 1'b1;
    else if (i_valid)
      o_ready <= ($random(seed) % 4 == 0);
  end
endmodule
`default_nettype wire

// ### sim/tb_hmse_store_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hmse_store_exec import hmse_pkg::*;;
  logic        I_CORE_CLK, I_RESETN, I_INSN_VALID, O_INSN_READY;
  logic        O_DONE, O_NOT_HANDLED, O_WB_VALID, I_DATA_RELOC;
  logic        I_USER_MODE, I_TLB_HIT, I_ZONE_NOACC, I_ZONE_RDONLY;
  logic        O_MEM_VALID, I_MEM_READY, O_DATA_STORAGE_EXC;
  logic        O_DTLB_MISS_EXC, slow;
  logic [31:0] I_INSN, I_RD_BASE_DATA, I_RD_INDEX_DATA, I_RD_SRC_DATA;
  logic [31:0] O_WB_DATA, O_MEM_ADDR, O_MEM_DATA, v, u;
  logic [4:0]  O_RD_BASE_IDX, O_RD_INDEX_IDX, O_RD_SRC_IDX, O_WB_IDX, rs;
  logic [2:0]  O_MEM_LEN;
  logic [19:0] fault_page;
  logic [1:0]  fault_kind;
  logic [31:0] rf [32];
  logic [66:0] mq [$];
  logic [36:0] wq [$];
  logic [3:0]  eq [$];
  hmse_kind_t  kk;
  integer      seed = 83497;
  int          failures = 0;
  int          checked = 0;

  hmse_store_exec dut (
    .I_CORE_CLK, .I_RESETN, .I_INSN_VALID, .I_INSN, .O_INSN_READY,
    .O_DONE, .O_NOT_HANDLED, .O_RD_BASE_IDX, .I_RD_BASE_DATA,
    .O_RD_INDEX_IDX, .I_RD_INDEX_DATA, .O_RD_SRC_IDX, .I_RD_SRC_DATA,
    .O_WB_VALID, .O_WB_IDX, .O_WB_DATA, .I_DATA_RELOC, .I_USER_MODE,
    .I_TLB_HIT, .I_ZONE_NOACC, .I_ZONE_RDONLY, .O_MEM_VALID,
    .I_MEM_READY, .O_MEM_ADDR, .O_MEM_DATA, .O_MEM_LEN,
    .O_DATA_STORAGE_EXC, .O_DTLB_MISS_EXC
  );

  hmse_mem_model mem (
    .i_clk(I_CORE_CLK), .i_valid(O_MEM_VALID), .i_addr(O_MEM_ADDR),
    .o_ready(I_MEM_READY), .o_tlb_hit(I_TLB_HIT),
    .o_zone_noacc(I_ZONE_NOACC), .o_zone_rdonly(I_ZONE_RDONLY),
    .i_slow(slow), .i_fault_page(fault_page), .i_fault_kind(fault_kind)
  );

  // register file reads are same-cycle
  assign I_RD_BASE_DATA  = rf[O_RD_BASE_IDX];
  assign I_RD_INDEX_DATA = rf[O_RD_INDEX_IDX];
  assign I_RD_SRC_DATA   = rf[O_RD_SRC_IDX];

  always #25 I_CORE_CLK = ~I_CORE_CLK;

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tally(bit ok, string what);
    checked++;
    if (!ok) begin
      failures++;
      $display("BAD %0t %s mismatch", $time, what);
    end
  endtask

  task automatic cmp_mem(logic [66:0] g, logic [66:0] e);
    tally(g === e, "store");
  endtask

  task automatic cmp_wb(logic [36:0] g, logic [36:0] e);
    tally(g === e, "writeback");
  endtask

  task automatic cmp_ev(logic [3:0] g, logic [3:0] e);
    tally(g === e, "event");
  endtask

  task automatic cmp_rdy(logic g, logic e);
    tally(g === e, "ready");
  endtask

  // anything with no note waiting is compared against unknown and fails
  always @(posedge I_CORE_CLK) begin
    if (I_RESETN === 1'b1) begin
      if (O_MEM_VALID === 1'b1 && I_MEM_READY === 1'b1)
        cmp_mem({O_MEM_ADDR, O_MEM_DATA, O_MEM_LEN},
                mq.size() ? mq.pop_front() : 'x);
      if (O_WB_VALID !== 1'b0) begin
        cmp_wb({O_WB_IDX, O_WB_DATA},
               wq.size() ? wq.pop_front() : 'x);
        rf[O_WB_IDX] <= O_WB_DATA;
      end
      if ({O_DONE, O_DATA_STORAGE_EXC, O_DTLB_MISS_EXC,
           O_NOT_HANDLED} !== 4'h0)
        cmp_ev({O_DONE, O_DATA_STORAGE_EXC, O_DTLB_MISS_EXC, O_NOT_HANDLED},
               eq.size() ? eq.pop_front() : 'x);
    end
  end

  task automatic issue(logic [31:0] w);
    int t;
    @(negedge I_CORE_CLK);
    I_INSN       = w;
    I_INSN_VALID = 1'b1;
    @(negedge I_CORE_CLK);
    I_INSN_VALID = 1'b0;
    // only a word outside the group leaves the block idle
    cmp_rdy(O_INSN_READY, eq[0] == 4'h1);
    for (t = 0; t < 300 && eq.size() != 0; t++)
      @(negedge I_CORE_CLK);
    if (eq.size() + mq.size() + wq.size() != 0)
      tally(1'b0, "missing result");
    eq.delete();
    mq.delete();
    wq.delete();
  endtask

  task automatic run(hmse_kind_t k, logic [4:0] s, logic [4:0] ra,
                     logic [4:0] rb, logic [15:0] d, logic rsv);
    logic [31:0] ea, a, x, w;
    logic        upd, idx, miss, dse;
    int          n;
    upd = (k == K_STHU) || (k == K_STHUX);
    idx = (k == K_STHX) || (k == K_STHUX) || (k == K_STHBRX);
    ea = ((ra != 5'h00 || upd) ? rf[ra] : 32'h0) +
         (idx ? rf[rb] : {{16{d[15]}}, d});
    case (k)
      K_STH:    w = {6'h2c, s, ra, d};
      K_STHU:   w = {6'h2d, s, ra, d};
      K_STMW:   w = {6'h2f, s, ra, d};
      K_STHX:   w = {6'h1f, s, ra, rb, 10'h197, rsv};
      K_STHUX:  w = {6'h1f, s, ra, rb, 10'h1b7, rsv};
      K_STHBRX: w = {6'h1f, s, ra, rb, 10'h396, rsv};
      default:  w = {6'h26, s, ra, d};
    endcase
    n = (k == K_STMW) ? 32 - s : 1;
    miss = 1'b0;
    dse = 1'b0;
    if (k == K_NONE) begin
      eq.push_back(4'h1);
      n = 0;
    end
    for (int i = 0; i < n && !miss && !dse; i++) begin
      a = ea + 32'(4 * i);
      miss = I_DATA_RELOC && a[31:12] == fault_page && fault_kind == 2'h1;
      dse = I_DATA_RELOC && !miss && a[31:12] == fault_page &&
            (fault_kind == 2'h3 || (fault_kind == 2'h2 && I_USER_MODE));
      x = rf[s + 5'(i)];
      if (miss || dse)
        eq.push_back(miss ? 4'h2 : 4'h4);
      else if (k == K_STMW)
        mq.push_back({a, x, 3'h4});
      else if (k == K_STHBRX)
        mq.push_back({a, 16'h0, x[7:0], x[15:8], 3'h2});
      else
        mq.push_back({a, 16'h0, x[15:0], 3'h2});
    end
    if (n != 0 && !miss && !dse) begin
      if (upd)
        wq.push_back({ra, ea});
      eq.push_back(4'h8);
    end
    issue(w);
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    #1000000;
    failures++;
    test_done;
  end

  initial begin
    I_CORE_CLK   = 1'b0;
    I_RESETN     = 1'b0;
    I_INSN_VALID = 1'b0;
    I_INSN       = 32'h0;
    I_DATA_RELOC = 1'b0;
    I_USER_MODE  = 1'b0;
    slow         = 1'b0;
    fault_page   = 20'h00041;
    fault_kind   = 2'h0;
    for (int r = 0; r < 32; r++)
      rf[r] = $random(seed);
    repeat (2) @(negedge I_CORE_CLK);
    I_RESETN = 1'b1;
    run(K_STH, 5'h03, 5'h00, 5'h00, 16'h8002, 1'b0);
    run(K_STHX, 5'h04, 5'h00, 5'h07, 16'h0, 1'b1);
    run(K_STHUX, 5'h06, 5'h08, 5'h09, 16'h0, 1'b0);
    run(K_STHBRX, 5'h0a, 5'h0b, 5'h0c, 16'h0, 1'b0);
    run(K_STMW, 5'h1f, 5'h02, 5'h00, 16'hfffc, 1'b0);
    run(K_NONE, 5'h01, 5'h02, 5'h00, 16'h0, 1'b0);
    run(K_STHU, 5'h09, 5'h00, 5'h00, 16'h0020, 1'b0);
    slow = 1'b1;
    run(K_STMW, 5'h18, 5'h01, 5'h00, 16'h0010, 1'b0);
    // every zone kind, both modes, relocation off and on
    rf[5] = 32'h0004_0ff8;
    for (int m = 0; m < 12; m++) begin
      I_DATA_RELOC = m[0];
      I_USER_MODE  = m[1];
      fault_kind   = 2'(m / 4 + 1);
      run(K_STHU, 5'h07, 5'h05, 5'h00, 16'h0010, 1'b0);
    end
    // fault on the third word keeps the first two
    I_DATA_RELOC = 1'b1;
    rf[6] = 32'h0004_0ff8;
    run(K_STMW, 5'h1c, 5'h06, 5'h00, 16'h0, 1'b0);
    fault_kind = 2'h0;
    for (int j = 0; j < 40; j++) begin
      v = $random(seed);
      u = $random(seed);
      slow         = v[0];
      I_DATA_RELOC = v[1];
      I_USER_MODE  = v[2];
      kk = hmse_kind_t'(3'h1 + 3'(v[5:3] % 6));
      rs = (kk == K_STMW) ? {2'b11, v[8:6]} : v[10:6];
      run(kk, rs, v[15:11], v[20:16], u[15:0], v[21]);
    end
    test_done;
  end
endmodule
`default_nettype wire
